// ==== core/sdbsm_pkg.sv ====
// Package: command codes, bank states and timing constants
package sdbsm_pkg;

  localparam int NUM_BANKS = 4;
  localparam int CLK_PERIOD_NS = 100;

  // Timing figures in ns; each is a least time, so counts round up
  localparam int PRECHARGE_TIME_NS          = 20;
  localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS      = 66;
  localparam int MODE_LOAD_TIME_NS          = 200;
  localparam int SELF_REFRESH_EXIT_TIME_NS  = 75;

  localparam int PRECHARGE_CYC =
    (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTIVATE_CYC =
    (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MODE_LOAD_CYC =
    (MODE_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_CYC =
    (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W = 8;

  // Strobe pattern {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_NOP       = 3'h7;
  localparam logic [2:0] CMD_ACTIVE    = 3'h3;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_BURST_END = 3'h6;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_MODE_LOAD = 3'h0;

  typedef enum logic [2:0] {
    SDBSM_BK_IDLE,
    SDBSM_BK_ACTIVATING,
    SDBSM_BK_ACTIVE,
    SDBSM_BK_READ,
    SDBSM_BK_WRITE,
    SDBSM_BK_READ_AP,
    SDBSM_BK_WRITE_AP,
    SDBSM_BK_PRECHARGING
  } sdbsm_bank_st_t;

  typedef enum logic [2:0] {
    SDBSM_DV_NORMAL,
    SDBSM_DV_REFRESHING,
    SDBSM_DV_MODE_ACCESS,
    SDBSM_DV_PRECHARGE_ALL,
    SDBSM_DV_EXIT_WAIT
  } sdbsm_dev_st_t;

  // Bank state codes as seen on the status outputs
  localparam logic [2:0] ST_CODE_IDLE = 3'h0;

endpackage : sdbsm_pkg

// ==== core/sdbsm_cmd_decode.sv ====
// Command decoder: registers pins, yields the strobe pattern as a three-bit command code
module sdbsm_cmd_decode
  import sdbsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       cke,
  input  wire logic       ap_bit,
  input  wire logic [1:0] bank_sel,
  output logic            valid,
  output logic [2:0]      cmd,
  output logic            ap,
  output logic [1:0]      bank
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic       cke_prev;
  } sdbsm_dec_t;

  sdbsm_dec_t q, d;

  always_comb begin
    d = q;
    d.s1 = {cs_n, ras_n, cas_n, we_n, cke, ap_bit, bank_sel};
    d.s2 = q.s1;
    d.cke_prev = q.s2[3];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{s1: 8'h80, s2: 8'h80, cke_prev: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Inhibit masks everything; clock gate must be high now and before
  assign valid = !q.s2[7] && q.s2[3] && q.cke_prev;
  assign cmd   = q.s2[6:4];
  assign ap    = q.s2[2];
  assign bank  = q.s2[1:0];

endmodule : sdbsm_cmd_decode

// ==== core/sdbsm_bank.sv ====
// One bank's state machine with its own timing counter
module sdbsm_bank
  import sdbsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sel,
  input  wire logic       cmd_ok,
  input  wire logic [2:0] cmd,
  input  wire logic       ap,
  input  wire logic       pre_all,
  input  wire logic       force_idle,
  input  wire logic       term,
  output sdbsm_bank_st_t  state
);

  typedef struct packed {
    sdbsm_bank_st_t     st;
    logic [TIMER_W-1:0] tmr;
  } sdbsm_bk_t;

  sdbsm_bk_t q, d;

  function automatic logic [TIMER_W-1:0] cyc(input int n);
    return TIMER_W'(n > 0 ? n - 1 : 0);
  endfunction : cyc

  always_comb begin
    logic hit;
    hit = cmd_ok && sel;
    d = q;
    if (q.tmr != '0) begin
      d.tmr = q.tmr - 1'b1;
    end
    unique case (q.st)
      SDBSM_BK_IDLE: begin
        // Precharge to an idle bank is a no-op here
        if (hit && cmd == CMD_ACTIVE) begin
          d.st  = SDBSM_BK_ACTIVATING;
          d.tmr = cyc(ACTIVATE_CYC);
        end
      end
      SDBSM_BK_ACTIVATING: begin
        // Commands to this bank are ignored until the row is ready
        if (q.tmr == '0) begin
          d.st = SDBSM_BK_ACTIVE;
        end
      end
      SDBSM_BK_ACTIVE, SDBSM_BK_READ, SDBSM_BK_WRITE: begin
        if (term && q.st != SDBSM_BK_ACTIVE) begin
          d.st = SDBSM_BK_ACTIVE;
        end
        if (cmd_ok && cmd == CMD_PRECHARGE && (sel || pre_all)) begin
          d.st  = SDBSM_BK_PRECHARGING;
          d.tmr = cyc(PRECHARGE_CYC);
        end else if (hit && cmd == CMD_READ) begin
          d.st = ap ? SDBSM_BK_READ_AP : SDBSM_BK_READ;
          d.tmr = cyc(PRECHARGE_CYC);
        end else if (hit && cmd == CMD_WRITE) begin
          d.st = ap ? SDBSM_BK_WRITE_AP : SDBSM_BK_WRITE;
          d.tmr = cyc(PRECHARGE_CYC);
        end
      end
      SDBSM_BK_READ_AP, SDBSM_BK_WRITE_AP, SDBSM_BK_PRECHARGING: begin
        if (q.tmr == '0) begin
          d.st = SDBSM_BK_IDLE;
        end
      end
      default: d.st = SDBSM_BK_IDLE;
    endcase
    if (force_idle) begin
      d.st  = SDBSM_BK_IDLE;
      d.tmr = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: SDBSM_BK_IDLE, tmr: '0};
    end else begin
      q <= d;
    end
  end

  assign state = q.st;

endmodule : sdbsm_bank

// ==== core/sdbsm_top.sv ====
// Top: four-bank command state machine of a synchronous DRAM
//
// Summary of operation
// - Chip select high registers no command; ongoing work continues.
// - Low select with all strobes high is a no-op.
// - Idle bank accepts activate, opening a row.
// - Mode load holds device busy for mode load time, then all idle.
// - Precharge to an idle bank changes nothing.
// - Row-active bank accepts read, with or without auto precharge.
// - Row-active or read bank accepts write, starting a burst.
// - Precharge closes the open row in one or all banks.
// - Read during read or write without auto precharge restarts read.
// - Precharge during plain read burst truncates it and precharges.
// - Precharge during plain write burst truncates it and precharges.
// - Write during plain write starts fresh write burst.
// - Burst terminate stops the latest read or write, any bank.
// - Commands act only with clock gate high now and before, after exit.
// - Bank is idle only after precharge time has elapsed.
// - Bank row-active once activate-to-access time met, no burst.
// - Activate enters activating, then active; precharge ends in idle.
// - Auto precharge access stays busy until precharge time, then idle.
// - Refresh holds device busy for refresh cycle time, then all idle.
// - Precharge-all holds device busy for precharge time, then idle.
// - Address bit ten on read or write selects auto precharge.
// - Address bit ten on precharge selects all banks, ignoring bank.
module sdbsm_top
  import sdbsm_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
) (
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic CS_N,
  input  wire logic ROW_STROBE_N,
  input  wire logic COL_STROBE_N,
  input  wire logic WRITE_STROBE_N,
  input  wire logic CLOCK_GATE,
  input  wire logic AUTO_PRECHARGE_ADDR_BIT,
  input  wire logic BANK_SELECT_LO,
  input  wire logic BANK_SELECT_HI,
  input  wire logic SELF_REFRESH_EXIT,
  output logic [11:0] BANK_STATE,
  output logic [2:0]  DEVICE_STATE,
  output logic        ALL_IDLE,
  output logic        CMD_ACCEPTED
);

  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  logic       cmd_v;
  logic [2:0] cmd;
  logic       ap;
  logic [1:0] bank;

  sdbsm_cmd_decode u_dec (
    .clk      (REF_CLK),
    .rst      (RST),
    .cs_n     (CS_N),
    .ras_n    (ROW_STROBE_N),
    .cas_n    (COL_STROBE_N),
    .we_n     (WRITE_STROBE_N),
    .cke      (CLOCK_GATE),
    .ap_bit   (AUTO_PRECHARGE_ADDR_BIT),
    .bank_sel ({BANK_SELECT_HI, BANK_SELECT_LO}),
    .valid    (cmd_v),
    .cmd      (cmd),
    .ap       (ap),
    .bank     (bank)
  );

  // --------------------------------------------------------------
  // Device-wide state
  // --------------------------------------------------------------
  typedef struct packed {
    sdbsm_dev_st_t      st;
    logic [TIMER_W-1:0] tmr;
    logic [1:0]         last_bank;
    logic               last_live;
    logic [2:0]         exit_s;
    logic               accepted;
  } sdbsm_top_t;

  sdbsm_top_t     q, d;
  sdbsm_bank_st_t bst [BANKS];
  logic           all_idle;
  logic           cmd_ok;
  logic           force_idle;
  logic           term;
  logic           pre_all;

  function automatic logic [TIMER_W-1:0] cyc(input int n);
    return TIMER_W'(n > 0 ? n - 1 : 0);
  endfunction : cyc

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (bst[i] != SDBSM_BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // Banks see commands only in normal state; no-op decodes as nothing
  assign cmd_ok = cmd_v && q.st == SDBSM_DV_NORMAL
                  && cmd != CMD_NOP;
  assign pre_all = ap && cmd == CMD_PRECHARGE;
  assign term = cmd_ok && cmd == CMD_BURST_END
                && q.last_live;

  always_comb begin
    d = q;
    // Two sync stages, third only for edge detection
    d.exit_s = {q.exit_s[1:0], SELF_REFRESH_EXIT};
    d.accepted = cmd_ok;
    force_idle = 1'b0;
    if (q.tmr != '0) begin
      d.tmr = q.tmr - 1'b1;
    end
    if (cmd_ok && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
      d.last_bank = bank;
      d.last_live = bst[bank] == SDBSM_BK_ACTIVE
                    || bst[bank] == SDBSM_BK_READ
                    || bst[bank] == SDBSM_BK_WRITE;
    end else if (term) begin
      d.last_live = 1'b0;
    end
    unique case (q.st)
      SDBSM_DV_NORMAL: begin
        // Refresh and mode load trusted only with all banks idle
        if (q.exit_s[2] && !q.exit_s[1]) begin
          d.st  = SDBSM_DV_EXIT_WAIT;
          d.tmr = cyc(SELF_REFRESH_EXIT_CYC);
        end else if (cmd_ok && all_idle) begin
          if (cmd == CMD_REFRESH) begin
            d.st  = SDBSM_DV_REFRESHING;
            d.tmr = cyc(REFRESH_CYC);
          end else if (cmd == CMD_MODE_LOAD) begin
            d.st  = SDBSM_DV_MODE_ACCESS;
            d.tmr = cyc(MODE_LOAD_CYC);
          end
        end
        if (cmd_ok && pre_all) begin
          d.st  = SDBSM_DV_PRECHARGE_ALL;
          d.tmr = cyc(PRECHARGE_CYC);
        end
      end
      SDBSM_DV_REFRESHING, SDBSM_DV_MODE_ACCESS,
      SDBSM_DV_PRECHARGE_ALL, SDBSM_DV_EXIT_WAIT: begin
        if (q.tmr == '0) begin
          d.st = SDBSM_DV_NORMAL;
          force_idle = 1'b1;
        end
      end
      default: d.st = SDBSM_DV_NORMAL;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '{st: SDBSM_DV_NORMAL, tmr: '0, last_bank: 2'h0,
             last_live: 1'b0, exit_s: 3'h0, accepted: 1'b0};
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // Bank state machines
  // --------------------------------------------------------------
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic sel;
    logic bterm;
    assign sel   = !pre_all && bank == 2'(b);
    assign bterm = term && q.last_bank == 2'(b);
    sdbsm_bank u_bank (
      .clk        (REF_CLK),
      .rst        (RST),
      .sel        (sel),
      .cmd_ok     (cmd_ok),
      .cmd        (cmd),
      .ap         (ap),
      .pre_all    (pre_all),
      .force_idle (force_idle),
      .term       (bterm),
      .state      (bst[b])
    );
    assign BANK_STATE[3*b +: 3] = bst[b];
  end

  assign DEVICE_STATE = q.st;
  assign ALL_IDLE     = all_idle && q.st == SDBSM_DV_NORMAL;
  assign CMD_ACCEPTED = q.accepted;

endmodule : sdbsm_top

// ==== dv/sdbsm_checker.sv ====
// Checker: port-level timing of the bank command state machine
module sdbsm_checker
  import sdbsm_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
) (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        CS_N,
  input wire logic        ROW_STROBE_N,
  input wire logic        COL_STROBE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        CLOCK_GATE,
  input wire logic        AUTO_PRECHARGE_ADDR_BIT,
  input wire logic        BANK_SELECT_LO,
  input wire logic        BANK_SELECT_HI,
  input wire logic        SELF_REFRESH_EXIT,
  input wire logic [11:0] BANK_STATE,
  input wire logic [2:0]  DEVICE_STATE,
  input wire logic        ALL_IDLE,
  input wire logic        CMD_ACCEPTED
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] d1_q, d2_q, d3_q, d4_q;
  logic [2:0] cmd, cur, nb, nb2;
  logic       go, ap;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Pins of edge N sit in d2_q at the edge where the command acts
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      {d1_q, d2_q, d3_q, d4_q} <= {4{8'hff}};
    end else begin
      d1_q <= {CS_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N,
               CLOCK_GATE, AUTO_PRECHARGE_ADDR_BIT, BANK_SELECT_HI,
               BANK_SELECT_LO};
      {d2_q, d3_q, d4_q} <= {d1_q, d2_q, d3_q};
    end
  end
  assign go = !d2_q[7] && d2_q[3] && d3_q[3] && DEVICE_STATE == 3'h0;
  assign cmd = d2_q[6:4];
  assign ap = d2_q[2];
  assign cur = BANK_STATE[3*d2_q[1:0] +: 3];
  assign nb = BANK_STATE[3*d3_q[1:0] +: 3];
  assign nb2 = BANK_STATE[3*d4_q[1:0] +: 3];
  property p_act;
    go && cmd == CMD_ACTIVE && cur == 3'h0 |=> nb == 3'h1 ##1 nb2 == 3'h2;
  endproperty
  a_act: assert property (p_act) else $error("activate");
  property p_rd;
    go && cmd == CMD_READ && !ap && cur inside {3'h2, 3'h3, 3'h4}
      |=> nb == 3'h3;
  endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_wr;
    go && cmd == CMD_WRITE && !ap && cur inside {3'h2, 3'h3, 3'h4}
      |=> nb == 3'h4;
  endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_ap;
    go && (cmd == CMD_READ || cmd == CMD_WRITE) && ap && cur == 3'h2
      |=> nb inside {3'h5, 3'h6} ##1 nb2 == 3'h0;
  endproperty
  a_ap: assert property (p_ap) else $error("auto pre");
  property p_pre;
    go && cmd == CMD_PRECHARGE && !ap && cur inside {3'h2, 3'h3, 3'h4}
      |=> nb == 3'h7 ##1 nb2 == 3'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge");
  property p_ref;
    go && cmd == CMD_REFRESH && ALL_IDLE
      |=> DEVICE_STATE == 3'h1 ##1 DEVICE_STATE == 3'h0;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh");
  property p_mode;
    go && cmd == CMD_MODE_LOAD && ALL_IDLE
      |=> DEVICE_STATE == 3'h2 [*2] ##1 DEVICE_STATE == 3'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode load");
  property p_inh;
    CS_N |-> ##3 !CMD_ACCEPTED;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit");
  property p_gate;
    !CLOCK_GATE |-> ##3 !CMD_ACCEPTED ##1 !CMD_ACCEPTED;
  endproperty
  a_gate: assert property (p_gate) else $error("clock gate");
endmodule : sdbsm_checker

bind sdbsm_top sdbsm_checker #(.BANKS(BANKS)) u_sdbsm_checker (.REF_CLK,
  .RST, .CS_N, .ROW_STROBE_N, .COL_STROBE_N, .WRITE_STROBE_N, .CLOCK_GATE,
  .AUTO_PRECHARGE_ADDR_BIT, .BANK_SELECT_LO, .BANK_SELECT_HI,
  .SELF_REFRESH_EXIT, .BANK_STATE, .DEVICE_STATE, .ALL_IDLE, .CMD_ACCEPTED);

// ==== dv/sdbsm_ctrl_model.sv ====
// Memory-controller model: one command per call, then a no-op
module sdbsm_ctrl_model
  import sdbsm_pkg::*;
(
  input  wire logic clk,
  output logic      cs_n,
  output logic      ras_n,
  output logic      cas_n,
  output logic      we_n,
  output logic      ap_bit,
  output logic      bank_lo,
  output logic      bank_hi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] drv = 7'h7f;
  assign {cs_n, ras_n, cas_n, we_n, ap_bit, bank_hi, bank_lo} = drv;
  // Address lines flip after use so a stale sample cannot pass
  task automatic issue(input logic sel_n, input logic [2:0] c,
                       input logic [1:0] b, input logic a);
    @(posedge clk);
    #10;
    drv = {sel_n, c, a, b};
    @(posedge clk);
    #10;
    drv = {1'b0, CMD_NOP, ~a, ~b};
  endtask : issue
endmodule : sdbsm_ctrl_model

// ==== dv/tb.sv ====
// Testbench: command sequences against the bank state machine
module tb
  import sdbsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CLOCK_GATE = 1'b1;
  logic        SELF_REFRESH_EXIT = 1'b0;
  logic        CS_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N;
  logic        AUTO_PRECHARGE_ADDR_BIT, BANK_SELECT_LO, BANK_SELECT_HI;
  logic [11:0] BANK_STATE;
  logic [2:0]  DEVICE_STATE;
  logic        ALL_IDLE, CMD_ACCEPTED;
  logic [2:0]  exp_st [4] = '{default: 3'h0};
  int          fail_count = 0;
  int          comparisons = 0;

  always #50 REF_CLK = ~REF_CLK;

  sdbsm_top u_sdbsm_top (.REF_CLK, .RST, .CS_N, .ROW_STROBE_N, .COL_STROBE_N,
    .WRITE_STROBE_N, .CLOCK_GATE, .AUTO_PRECHARGE_ADDR_BIT, .BANK_SELECT_LO,
    .BANK_SELECT_HI, .SELF_REFRESH_EXIT, .BANK_STATE, .DEVICE_STATE,
    .ALL_IDLE, .CMD_ACCEPTED);
  sdbsm_ctrl_model u_sdbsm_ctrl_model (.clk(REF_CLK), .cs_n(CS_N),
    .ras_n(ROW_STROBE_N), .cas_n(COL_STROBE_N), .we_n(WRITE_STROBE_N),
    .ap_bit(AUTO_PRECHARGE_ADDR_BIT), .bank_lo(BANK_SELECT_LO),
    .bank_hi(BANK_SELECT_HI));

  task automatic check(logic ok, string m);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : check
  // Whole vector compared, so a stray change in another bank shows too
  task automatic cmp_bank(int b, logic [2:0] st);
    exp_st[b] = st;
    check(BANK_STATE === {exp_st[3], exp_st[2], exp_st[1], exp_st[0]},
          "bank state");
  endtask : cmp_bank
  task automatic cmp_dev(logic [2:0] st);
    check(DEVICE_STATE === st, "device state");
  endtask : cmp_dev
  task automatic cmp_bit(logic got, logic exp);
    check(got === exp, "flag");
  endtask : cmp_bit
  task automatic step(int n);
    repeat (n) @(posedge REF_CLK);
    #10;
  endtask : step
  // Returns in the cycle where the command's result first shows
  task automatic do_cmd(logic [2:0] c, logic [1:0] b, logic a);
    u_sdbsm_ctrl_model.issue(1'b0, c, b, a);
    step(2);
  endtask : do_cmd

  task automatic s_bursts();
    do_cmd(CMD_ACTIVE, 2'h1, 1'b0);
    cmp_bank(1, 3'h1);
    cmp_bit(CMD_ACCEPTED, 1'b1);
    step(1);
    cmp_bank(1, 3'h2);
    do_cmd(CMD_READ, 2'h1, 1'b0);
    cmp_bank(1, 3'h3);
    do_cmd(CMD_WRITE, 2'h1, 1'b0);
    cmp_bank(1, 3'h4);
    do_cmd(CMD_WRITE, 2'h1, 1'b0);
    cmp_bank(1, 3'h4);
    do_cmd(CMD_READ, 2'h1, 1'b0);
    cmp_bank(1, 3'h3);
    do_cmd(CMD_BURST_END, 2'h2, 1'b0);
    cmp_bank(1, 3'h2);
    do_cmd(CMD_READ, 2'h1, 1'b0);
    do_cmd(CMD_PRECHARGE, 2'h1, 1'b0);
    cmp_bank(1, 3'h7);
    step(1);
    cmp_bank(1, 3'h0);
  endtask : s_bursts

  task automatic s_write_pre();
    do_cmd(CMD_ACTIVE, 2'h2, 1'b0);
    step(1);
    cmp_bank(2, 3'h2);
    do_cmd(CMD_WRITE, 2'h2, 1'b0);
    do_cmd(CMD_PRECHARGE, 2'h2, 1'b0);
    cmp_bank(2, 3'h7);
    step(1);
    cmp_bank(2, 3'h0);
    do_cmd(CMD_PRECHARGE, 2'h0, 1'b0);
    cmp_bank(0, 3'h0);
    cmp_bit(CMD_ACCEPTED, 1'b1);
  endtask : s_write_pre

  task automatic s_auto();
    for (int i = 0; i < 2; i++) begin
      do_cmd(CMD_ACTIVE, 2'h3, 1'b0);
      step(1);
      cmp_bank(3, 3'h2);
      do_cmd(i ? CMD_WRITE : CMD_READ, 2'h3, 1'b1);
      cmp_bank(3, i ? 3'h6 : 3'h5);
      step(1);
      cmp_bank(3, 3'h0);
    end
  endtask : s_auto

  task automatic s_ignore();
    u_sdbsm_ctrl_model.issue(1'b1, CMD_ACTIVE, 2'h0, 1'b0);
    step(2);
    cmp_bank(0, 3'h0);
    cmp_bit(CMD_ACCEPTED, 1'b0);
    do_cmd(CMD_NOP, 2'h0, 1'b0);
    cmp_bit(CMD_ACCEPTED, 1'b0);
    CLOCK_GATE = 1'b0;
    do_cmd(CMD_ACTIVE, 2'h0, 1'b0);
    cmp_bank(0, 3'h0);
    CLOCK_GATE = 1'b1;
  endtask : s_ignore

  task automatic s_device();
    do_cmd(CMD_REFRESH, 2'h0, 1'b0);
    cmp_dev(3'h1);
    step(1);
    cmp_dev(3'h0);
    do_cmd(CMD_MODE_LOAD, 2'h0, 1'b0);
    cmp_dev(3'h2);
    step(1);
    cmp_dev(3'h2);
    step(1);
    cmp_dev(3'h0);
    do_cmd(CMD_ACTIVE, 2'h0, 1'b0);
    do_cmd(CMD_ACTIVE, 2'h1, 1'b0);
    step(1);
    exp_st[1] = 3'h2;
    cmp_bank(0, 3'h2);
    do_cmd(CMD_PRECHARGE, 2'h2, 1'b1);
    cmp_dev(3'h3);
    step(1);
    exp_st[1] = 3'h0;
    cmp_bank(0, 3'h0);
    cmp_bit(ALL_IDLE, 1'b1);
  endtask : s_device

  // First pass watches the wait state, second sends a command into it
  task automatic s_exit();
    for (int i = 0; i < 2; i++) begin
      SELF_REFRESH_EXIT = 1'b1;
      step(3);
      SELF_REFRESH_EXIT = 1'b0;
      if (i == 0) begin
        step(3);
        cmp_dev(3'h4);
        step(1);
        cmp_dev(3'h0);
      end else begin
        do_cmd(CMD_ACTIVE, 2'h0, 1'b0);
        cmp_bank(0, 3'h0);
        cmp_bit(CMD_ACCEPTED, 1'b0);
      end
    end
  endtask : s_exit

  // Reset in mid-run, then a command right after release
  task automatic s_reset();
    do_cmd(CMD_ACTIVE, 2'h3, 1'b0);
    cmp_bank(3, 3'h1);
    RST = 1'b1;
    step(1);
    exp_st = '{default: 3'h0};
    cmp_bank(3, 3'h0);
    cmp_dev(3'h0);
    cmp_bit(CMD_ACCEPTED, 1'b0);
    cmp_bit(ALL_IDLE, 1'b1);
    RST = 1'b0;
    do_cmd(CMD_ACTIVE, 2'h2, 1'b0);
    cmp_bank(2, 3'h1);
  endtask : s_reset

  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    step(4);
    RST = 1'b0;
    s_bursts();
    s_write_pre();
    s_auto();
    s_ignore();
    s_device();
    s_exit();
    s_reset();
    final_report();
  end
  // About 140 cycles of tests; this cuts off far beyond that
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule : tb
